// ===== pkg/usync_defines.svh
// Register offsets, bit positions and reset values of the synchronous serial block.
`ifndef USYNC_DEFINES_SVH
`define USYNC_DEFINES_SVH
`define USYNC_OFF_INT_CTRL   8'h00
`define USYNC_OFF_PFLAGS     8'h04
`define USYNC_OFF_PENABLES   8'h08
`define USYNC_OFF_PPRIO      8'h0c
`define USYNC_OFF_RX_STAT    8'h10
`define USYNC_OFF_TX_BUF     8'h14
`define USYNC_OFF_TX_STAT    8'h18
`define USYNC_OFF_BAUD       8'h1c
`define USYNC_OFF_RX_BUF     8'h20
`define USYNC_RST_ZERO       8'h00
`define USYNC_RST_PPRIO      8'hff
`define USYNC_B_PORT_EN      7
`define USYNC_B_RX_NINE_EN   6
`define USYNC_B_SINGLE_RX    5
`define USYNC_B_CONT_RX      4
`define USYNC_B_ADDR_DET     3
`define USYNC_B_FRAME_ERR    2
`define USYNC_B_OVR_ERR      1
`define USYNC_B_RX_NINTH     0
`define USYNC_B_CLK_SRC      7
`define USYNC_B_TX_NINE_EN   6
`define USYNC_B_TX_EN        5
`define USYNC_B_SYNC_SEL     4
`define USYNC_B_HI_SPEED     2
`define USYNC_B_SHIFT_EMPTY  1
`define USYNC_B_TX_NINTH     0
`define USYNC_B_RX_DONE      5
`define USYNC_B_TX_EMPTY     4
`define USYNC_B_GLOBAL_IE    7
`define USYNC_BITS_EIGHT     4'h8
`define USYNC_BITS_NINE      4'h9
`define USYNC_HSIZE_WORD     3'h2
`endif

// ===== pkg/usync_pkg.sv
// Types shared by the synchronous serial block.
package usync_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TX   = 2'b01,
      ST_RX   = 2'b10
   } usync_state_t;

   typedef struct packed {
      logic ck_o;
      logic ck_oe;
      logic dt_o;
      logic dt_oe;
   } usync_pins_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       write;
      logic       valid;
   } usync_aph_t;
endpackage

// ===== logic/usync_top.sv
// Synchronous half-duplex serial transceiver with an AHB-Lite register slave.
`timescale 1ns/10ps
`include "usync_defines.svh"

// How it works
// - Shift register reloads only when idle, straight from a full transmit buffer.
// - Buffer to shift register move takes one cycle; buffer then empty, flag sets.
// - Transmit empty flag ignores its enable, software cannot clear it.
// - After a buffer write the empty flag drops in the second cycle.
// - Shift empty bit is read-only, high while the shift register is empty.
// - Transmit interrupt request is gated by its enable bit.
// - With nine-bit transmit the ninth bit is shifted out after bit seven.
// - Master reception starts on single or continuous receive enable.
// - Received data is sampled on the falling shift clock edge.
// - Single receive takes exactly one word then stops.
// - Continuous receive runs until cleared or an overrun, and wins over single receive.
// - Nine-bit receive captures a ninth bit per word.
// - Complete word sets the receive flag; interrupt only when enabled.
// - Ninth bit and errors in status register, low byte in receive buffer.
// - Clearing continuous receive clears receive errors.
// - Clock source clear selects slave; the peer drives the clock pin.
// - Slave shifting continues in sleep since the peer clocks it.
// - During sleep a second buffered word waits, then moves and sets the flag.
// - Enabled transmit interrupt wakes the core; vectors with global enable.
// - Master mode drives the shift clock from the divisor.
// - Half duplex: transmit and receive exclude each other.
module usync_top (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   input  wire logic               sleep_mode,
   input  wire logic               shift_clock_pin_i,
   input  wire logic               serial_data_pin_i,
   output usync_pkg::usync_pins_t  pins,
   output logic                    wake_req,
   output logic                    irq_req
);
   usync_pkg::usync_state_t state_q;
   usync_pkg::usync_aph_t   aph_q;
   logic       rd_wait_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;
   logic [7:0] int_ctrl_q, penables_q, pprio_q, baud_q, tx_buf_q, rx_buf_q, baud_cnt_q;
   logic       port_en_q, rx_nine_q, single_rx_q, cont_rx_q, addr_det_q, ovr_q, rx_ninth_q;
   logic       clk_src_q, tx_nine_q, tx_en_q, sync_sel_q, hi_speed_q, tx_ninth_q;
   logic       full_q, tx_buffer_empty_flag_q, rx_complete_flag_q, ck_q, wake_q, irq_q;
   logic       ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q;
   logic [8:0] tsr_q, rsr_q, rx_next;
   logic [3:0] bit_cnt_q;
   logic       take, wr_en, rd_rx_buf, running, tick, fall;
   logic       tx_ok, rx_en, tx_load, rx_done, overrun, wr_tx;

   // Address phase is taken only for whole-word transfers; others are ignored.
   assign take      = hsel & htrans[1] & hready & (hsize == `USYNC_HSIZE_WORD);
   assign wr_en     = aph_q.valid & aph_q.write;
   assign wr_tx     = wr_en & (aph_q.addr == `USYNC_OFF_TX_BUF);
   assign rd_rx_buf = rd_wait_q & (aph_q.addr == `USYNC_OFF_RX_BUF);
   assign hreadyout = ~rd_wait_q;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   // Reads take one wait state so that read data leaves a flip-flop.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aph_q     <= '0;
         rd_wait_q <= 1'b0;
         hrdata_q  <= 32'h00000000;
      end else begin
         if (hready) begin
            aph_q     <= '{addr: haddr[7:0], write: hwrite, valid: take};
            rd_wait_q <= take & ~hwrite;
         end else begin
            rd_wait_q <= 1'b0;
         end
         if (rd_wait_q) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   // Register read decode; unmapped offsets read as zero.
   always_comb begin
      rd_mux = 32'h00000000;
      if (aph_q.addr == `USYNC_OFF_INT_CTRL) begin
         rd_mux[7:0] = int_ctrl_q;
      end else if (aph_q.addr == `USYNC_OFF_PFLAGS) begin
         rd_mux[`USYNC_B_RX_DONE]  = rx_complete_flag_q;
         rd_mux[`USYNC_B_TX_EMPTY] = tx_buffer_empty_flag_q;
      end else if (aph_q.addr == `USYNC_OFF_PENABLES) begin
         rd_mux[7:0] = penables_q;
      end else if (aph_q.addr == `USYNC_OFF_PPRIO) begin
         rd_mux[7:0] = pprio_q;
      end else if (aph_q.addr == `USYNC_OFF_RX_STAT) begin
         rd_mux[7:0] = {port_en_q, rx_nine_q, single_rx_q, cont_rx_q, addr_det_q,
                        1'b0, ovr_q, rx_ninth_q};
      end else if (aph_q.addr == `USYNC_OFF_TX_BUF) begin
         rd_mux[7:0] = tx_buf_q;
      end else if (aph_q.addr == `USYNC_OFF_TX_STAT) begin
         rd_mux[7:0] = {clk_src_q, tx_nine_q, tx_en_q, sync_sel_q, 1'b0, hi_speed_q,
                        state_q != usync_pkg::ST_TX, tx_ninth_q};
      end else if (aph_q.addr == `USYNC_OFF_BAUD) begin
         rd_mux[7:0] = baud_q;
      end else if (aph_q.addr == `USYNC_OFF_RX_BUF) begin
         rd_mux[7:0] = rx_buf_q;
      end
   end

   // Plain configuration registers; the flag register takes no software writes.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_ctrl_q <= `USYNC_RST_ZERO;
         penables_q <= `USYNC_RST_ZERO;
         pprio_q    <= `USYNC_RST_PPRIO;
         baud_q     <= `USYNC_RST_ZERO;
         clk_src_q  <= 1'b0;
         tx_nine_q  <= 1'b0;
         tx_en_q    <= 1'b0;
         sync_sel_q <= 1'b0;
         hi_speed_q <= 1'b0;
         tx_ninth_q <= 1'b0;
         port_en_q  <= 1'b0;
         rx_nine_q  <= 1'b0;
         addr_det_q <= 1'b0;
      end else if (wr_en) begin
         if (aph_q.addr == `USYNC_OFF_INT_CTRL) begin
            int_ctrl_q <= hwdata[7:0];
         end else if (aph_q.addr == `USYNC_OFF_PENABLES) begin
            penables_q <= hwdata[7:0];
         end else if (aph_q.addr == `USYNC_OFF_PPRIO) begin
            pprio_q <= hwdata[7:0];
         end else if (aph_q.addr == `USYNC_OFF_BAUD) begin
            baud_q <= hwdata[7:0];
         end else if (aph_q.addr == `USYNC_OFF_TX_STAT) begin
            clk_src_q  <= hwdata[`USYNC_B_CLK_SRC];
            tx_nine_q  <= hwdata[`USYNC_B_TX_NINE_EN];
            tx_en_q    <= hwdata[`USYNC_B_TX_EN];
            sync_sel_q <= hwdata[`USYNC_B_SYNC_SEL];
            hi_speed_q <= hwdata[`USYNC_B_HI_SPEED];
            tx_ninth_q <= hwdata[`USYNC_B_TX_NINTH];
         end else if (aph_q.addr == `USYNC_OFF_RX_STAT) begin
            port_en_q  <= hwdata[`USYNC_B_PORT_EN];
            rx_nine_q  <= hwdata[`USYNC_B_RX_NINE_EN];
            addr_det_q <= hwdata[`USYNC_B_ADDR_DET];
         end
      end
   end

   // Receive enables; the hardware clear of single receive beats a same-cycle write.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         single_rx_q <= 1'b0;
         cont_rx_q   <= 1'b0;
      end else begin
         if (wr_en && aph_q.addr == `USYNC_OFF_RX_STAT) begin
            single_rx_q <= hwdata[`USYNC_B_SINGLE_RX];
            cont_rx_q   <= hwdata[`USYNC_B_CONT_RX];
         end
         if (rx_done && !cont_rx_q) begin
            single_rx_q <= 1'b0;
         end
      end
   end

   // Pin inputs cross into clk through two flops; the third only feeds edge finding.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         dt_s1_q <= 1'b0;
         dt_s2_q <= 1'b0;
      end else begin
         ck_s1_q <= shift_clock_pin_i;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         dt_s1_q <= serial_data_pin_i;
         dt_s2_q <= dt_s1_q;
      end
   end

   // Mode qualifiers; overrun halts reception until software clears continuous receive.
   assign tx_ok   = port_en_q & sync_sel_q & tx_en_q;
   assign rx_en   = port_en_q & sync_sel_q & ~ovr_q &
                    (cont_rx_q | (single_rx_q & clk_src_q));
   assign tx_load = (state_q == usync_pkg::ST_IDLE) & full_q & tx_ok & ~rx_en;

   // Master clock halts in sleep; a slave follows the peer clock regardless.
   assign running = (state_q != usync_pkg::ST_IDLE) & clk_src_q & ~sleep_mode;
   assign tick    = running & (baud_cnt_q == 8'h00);
   assign fall    = clk_src_q ? (tick & ck_q) : (ck_s3_q & ~ck_s2_q);

   // Divisor gives a half period of divisor plus one cycles.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         baud_cnt_q <= 8'h00;
         ck_q       <= 1'b0;
      end else begin
         if (!running || baud_cnt_q == 8'h00) begin
            baud_cnt_q <= baud_q;
         end else begin
            baud_cnt_q <= baud_cnt_q - 8'h01;
         end
         if (state_q == usync_pkg::ST_IDLE || !clk_src_q) begin
            ck_q <= 1'b0;
         end else if (tick) begin
            ck_q <= ~ck_q;
         end
      end
   end

   // Received bits enter at the top, so after the last one the word fills bits 8:0, or bits 8:1 in eight-bit mode.
   assign rx_next = {dt_s2_q, rsr_q[8:1]};
   assign rx_done = (state_q == usync_pkg::ST_RX) & rx_en & fall & (bit_cnt_q == 4'h1);
   assign overrun = rx_done & rx_complete_flag_q & ~rd_rx_buf;

   // Shift engine shared by transmit and receive, which never run together.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q   <= usync_pkg::ST_IDLE;
         tsr_q     <= 9'h000;
         rsr_q     <= 9'h000;
         bit_cnt_q <= 4'h0;
      end else begin
         case (state_q)
            usync_pkg::ST_IDLE: begin
               if (tx_load) begin
                  state_q   <= usync_pkg::ST_TX;
                  tsr_q     <= {tx_nine_q & tx_ninth_q, tx_buf_q};
                  bit_cnt_q <= tx_nine_q ? `USYNC_BITS_NINE : `USYNC_BITS_EIGHT;
               end else if (rx_en) begin
                  state_q   <= usync_pkg::ST_RX;
                  bit_cnt_q <= rx_nine_q ? `USYNC_BITS_NINE : `USYNC_BITS_EIGHT;
               end
            end
            usync_pkg::ST_TX: begin
               if (!tx_ok) begin
                  state_q <= usync_pkg::ST_IDLE;
               end else if (fall) begin
                  if (bit_cnt_q == 4'h1) begin
                     state_q <= usync_pkg::ST_IDLE;
                  end else begin
                     tsr_q     <= {1'b0, tsr_q[8:1]};
                     bit_cnt_q <= bit_cnt_q - 4'h1;
                  end
               end
            end
            usync_pkg::ST_RX: begin
               if (!rx_en) begin
                  state_q <= usync_pkg::ST_IDLE;
               end else if (fall) begin
                  rsr_q <= rx_next;
                  if (bit_cnt_q == 4'h1) begin
                     bit_cnt_q <= rx_nine_q ? `USYNC_BITS_NINE : `USYNC_BITS_EIGHT;
                     if (!cont_rx_q) begin
                        state_q <= usync_pkg::ST_IDLE;
                     end
                  end else begin
                     bit_cnt_q <= bit_cnt_q - 4'h1;
                  end
               end
            end
            default: begin
               state_q <= usync_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Transmit buffer; a write in the move cycle keeps the buffer full with new data.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_buf_q <= `USYNC_RST_ZERO;
         full_q   <= 1'b0;
         tx_buffer_empty_flag_q   <= 1'b0;
      end else begin
         if (wr_tx) begin
            tx_buf_q <= hwdata[7:0];
            full_q   <= 1'b1;
         end else if (tx_load) begin
            full_q <= 1'b0;
         end
         // One flop behind the buffer state, so a write shows in the second cycle.
         tx_buffer_empty_flag_q <= tx_en_q & ~full_q;
      end
   end

   // Receive result; an overrun keeps the unread word and raises the error.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_buf_q   <= `USYNC_RST_ZERO;
         rx_ninth_q <= 1'b0;
         rx_complete_flag_q     <= 1'b0;
         ovr_q      <= 1'b0;
      end else begin
         if (rx_done && !overrun) begin
            rx_buf_q   <= rx_nine_q ? rx_next[7:0] : rx_next[8:1];
            rx_ninth_q <= rx_nine_q & rx_next[8];
            rx_complete_flag_q     <= 1'b1;
         end else if (rd_rx_buf) begin
            rx_complete_flag_q <= 1'b0;
         end
         if (overrun) begin
            ovr_q <= 1'b1;
         end else if (!cont_rx_q) begin
            ovr_q <= 1'b0;
         end
      end
   end

   // Wake and vector requests; the core itself decides how to act on them.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_q <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         wake_q <= (tx_buffer_empty_flag_q & penables_q[`USYNC_B_TX_EMPTY]) |
                   (rx_complete_flag_q & penables_q[`USYNC_B_RX_DONE]);
         irq_q  <= ((tx_buffer_empty_flag_q & penables_q[`USYNC_B_TX_EMPTY]) |
                    (rx_complete_flag_q & penables_q[`USYNC_B_RX_DONE])) &
                   int_ctrl_q[`USYNC_B_GLOBAL_IE];
      end
   end

   // Pin drive; the clock is driven only by a master, data only while transmitting.
   assign wake_req    = wake_q;
   assign irq_req     = irq_q;
   assign pins.ck_o   = ck_q;
   assign pins.ck_oe  = port_en_q & sync_sel_q & clk_src_q;
   assign pins.dt_o   = tsr_q[0];
   assign pins.dt_oe  = port_en_q & sync_sel_q & (state_q == usync_pkg::ST_TX);

   // Checks on the transmit and receive paths.
   property p_tx_buffer_empty_flag_delay;
      @(posedge clk) disable iff (rst) wr_tx && tx_en_q |-> ##2 !tx_buffer_empty_flag_q;
   endproperty
   a_tx_buffer_empty_flag_delay: assert property (p_tx_buffer_empty_flag_delay) else $error("empty flag not low at +2");
   property p_move_one;
      @(posedge clk) disable iff (rst)
         tx_load && !wr_tx |=> !full_q && state_q == usync_pkg::ST_TX;
   endproperty
   a_move_one: assert property (p_move_one) else $error("buffer move not in one cycle");
   property p_load_idle;
      @(posedge clk) disable iff (rst) tx_load |-> state_q == usync_pkg::ST_IDLE && !rx_en;
   endproperty
   a_load_idle: assert property (p_load_idle) else $error("load while shifting");
   property p_tx_buffer_empty_flag_fall;
      @(posedge clk) disable iff (rst) $fell(tx_buffer_empty_flag_q) |-> $past(full_q) || !$past(tx_en_q);
   endproperty
   a_tx_buffer_empty_flag_fall: assert property (p_tx_buffer_empty_flag_fall) else $error("empty flag fell without data");
   property p_single;
      @(posedge clk) disable iff (rst)
         rx_done && !cont_rx_q |=> !single_rx_q && state_q == usync_pkg::ST_IDLE;
   endproperty
   a_single: assert property (p_single) else $error("single receive did not stop");
   property p_rx_edge;
      @(posedge clk) disable iff (rst) rx_done |-> fall;
   endproperty
   a_rx_edge: assert property (p_rx_edge) else $error("word ended off the falling edge");
   property p_rx_complete_flag;
      @(posedge clk) disable iff (rst) rx_done && !rx_complete_flag_q |=> rx_complete_flag_q && !ovr_q;
   endproperty
   a_rx_complete_flag: assert property (p_rx_complete_flag) else $error("receive flag not set");
   property p_ck_drive;
      @(posedge clk) disable iff (rst)
         clk_src_q && state_q != usync_pkg::ST_IDLE && $changed(ck_q) |-> $past(tick);
   endproperty
   a_ck_drive: assert property (p_ck_drive) else $error("clock drive wrong for mode");
   property p_wake;
      @(posedge clk) disable iff (rst)
         tx_buffer_empty_flag_q && penables_q[`USYNC_B_TX_EMPTY] |=> wake_q;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on transmit empty");
   property p_ovr_clear;
      @(posedge clk) disable iff (rst) ovr_q && !cont_rx_q && !overrun |=> !ovr_q;
   endproperty
   a_ovr_clear: assert property (p_ovr_clear) else $error("error not cleared");
   property p_c_tx;
      @(posedge clk) disable iff (rst) tx_load ##1 full_q;
   endproperty
   c_tx: cover property (p_c_tx);
   property p_c_cont;
      @(posedge clk) disable iff (rst) rx_done && cont_rx_q;
   endproperty
   c_cont: cover property (p_c_cont);
   property p_c_ovr;
      @(posedge clk) disable iff (rst) overrun;
   endproperty
   c_ovr: cover property (p_c_ovr);
endmodule

// ===== dv/usync_peer.sv
// Behavioural serial peer that clocks, captures and serves bits on the link.
`timescale 1ns/10ps
module usync_peer (
   input  wire logic ck_o,
   input  wire logic ck_oe,
   input  wire logic dt_o,
   input  wire logic dt_oe,
   output logic      ck_i,
   output logic      dt_i
);
   logic        pck = 1'b0;
   logic        pdt = 1'b0;
   logic [17:0] sh  = '0;
   int          nb  = 0;
   bit          q[$];

   // Clock stands low between frames; an undriven data line shows a changing pattern.
   assign ck_i = ck_oe ? ck_o : pck;
   assign dt_i = dt_oe ? dt_o : pdt;

   // Capture mid-bit on the rise, clear of the edge where the device shifts.
   always @(posedge ck_i) begin
      sh = {dt_i, sh[17:1]};
      nb = nb + 1;
      pdt = (q.size() > 0) ? q.pop_front() : ~pdt;
   end

   // Slave-mode shift clock of 80 ns, running only for the pulses asked for.
   task automatic pulses(input int n);
      repeat (n) begin
         #40 pck = 1'b1;
         #40 pck = 1'b0;
      end
   endtask
endmodule

// ===== dv/usync_top_test.sv
// Self-checking bench for the synchronous serial block and its register map.
`timescale 1ns/10ps
`include "usync_defines.svh"
module usync_top_test;
   logic                   clk;
   logic                   rst        = 1'b1;
   logic                   hsel       = 1'b0;
   logic [31:0]            haddr      = '0;
   logic [1:0]             htrans     = 2'b00;
   logic                   hwrite     = 1'b0;
   logic [2:0]             hsize      = `USYNC_HSIZE_WORD;
   logic [31:0]            hwdata     = '0;
   logic [31:0]            hrdata;
   logic                   hreadyout;
   logic                   hresp;
   logic                   sleep_mode = 1'b0;
   logic                   ck_i;
   logic                   dt_i;
   usync_pkg::usync_pins_t pins;
   logic                   wake_req;
   logic                   irq_req;
   logic [31:0]            seed       = 32'h42ed;
   logic [7:0]             v;
   logic [7:0]             a;
   logic [7:0]             b;
   logic [7:0]             rdat;
   logic [8:0]             e;
   int                     fails      = 0;
   int                     cmp_count  = 0;
   logic [7:0]             offs [9]   = '{`USYNC_OFF_INT_CTRL, `USYNC_OFF_PFLAGS,
      `USYNC_OFF_PENABLES, `USYNC_OFF_PPRIO, `USYNC_OFF_RX_STAT, `USYNC_OFF_TX_BUF,
      `USYNC_OFF_TX_STAT, `USYNC_OFF_BAUD, `USYNC_OFF_RX_BUF};
   logic [7:0]             exps [9]   = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00,
      8'h02, 8'h00, 8'h00};

   usync_top i_usync_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sleep_mode(sleep_mode),
      .shift_clock_pin_i(ck_i), .serial_data_pin_i(dt_i), .pins(pins),
      .wake_req(wake_req), .irq_req(irq_req));
   usync_peer i_usync_peer (.ck_o(pins.ck_o), .ck_oe(pins.ck_oe), .dt_o(pins.dt_o),
      .dt_oe(pins.dt_oe), .ck_i(ck_i), .dt_i(dt_i));

   // Bench clock of 4 ns.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Pseudo-random bytes from a fixed-seed shift register.
   function logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction

   // Verdict, reached from the main sequence or the watchdog.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One comparison; case inequality so an unknown never matches.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t saw %h want %h", $time, got, exp);
      end
   endtask

   // Ready is sampled mid-cycle, where it is settled, and taken at the next rise.
   task automatic wait_rdy();
      int   n;
      logic r;
      n = 0;
      do begin
         @(negedge clk);
         r = hreadyout;
         rdat = hrdata[7:0];
         @(posedge clk);
         n++;
      end while (r !== 1'b1 && n < 20);
      if (r !== 1'b1) begin
         fails++;
         $display("FAIL %0t bus never ready", $time);
      end
   endtask

   // Single word transfer: address phase, then data phase, each held until ready.
   task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h000000, ad};
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, wd};
      wait_rdy();
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
      bus(1'b1, ad, wd);
   endtask

   task automatic rd(input logic [7:0] ad, output logic [7:0] x);
      bus(1'b0, ad, 8'h00);
      x = rdat;
   endtask

   // Poll a register bit under a bound; the caller judges the last value.
   task automatic poll(input logic [7:0] ad, input int k, input logic val, output logic [7:0] x);
      int n;
      n = 0;
      do begin
         rd(ad, x);
         n++;
      end while (x[k] !== val && n < 500);
   endtask

   task automatic wait_bits(input int n);
      int k;
      k = 0;
      while (i_usync_peer.nb < n && k < 3000) begin
         @(posedge clk);
         k++;
      end
      if (i_usync_peer.nb < n) begin
         fails++;
         $display("FAIL %0t link bits never arrived", $time);
      end
   endtask

   // Queue bits for the peer to serve, least significant first.
   task automatic send(input logic [8:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         i_usync_peer.q.push_back(w[i]);
      end
   endtask

   // Watchdog well beyond the expected run length.
   initial begin
      #40000;
      fails++;
      end_sim();
   end

   // Main sequence: map, master transmit, master receive, slave transmit in sleep.
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         rd(offs[i], v);
         chk(v, exps[i]);
      end
      wr(8'h24, 8'hff);
      rd(8'h24, v);
      chk(v, 8'h00);
      wr(`USYNC_OFF_BAUD, 8'h03);
      wr(`USYNC_OFF_RX_STAT, 8'h80);
      wr(`USYNC_OFF_TX_STAT, 8'hb0);
      wr(`USYNC_OFF_PFLAGS, 8'h00);
      rd(`USYNC_OFF_PFLAGS, v);
      chk(v, 8'h10);
      a = rnd();
      b = rnd();
      i_usync_peer.nb = 0;
      wr(`USYNC_OFF_TX_BUF, a);
      repeat (4) @(posedge clk);
      wr(`USYNC_OFF_TX_BUF, b);
      rd(`USYNC_OFF_TX_STAT, v);
      chk(v, 8'hb0);
      wait_bits(16);
      chk(i_usync_peer.sh[17:2], {b, a});
      repeat (30) @(posedge clk);
      rd(`USYNC_OFF_TX_STAT, v);
      chk(v, 8'hb2);
      chk(wake_req, 1'b0);
      wr(`USYNC_OFF_TX_STAT, 8'hf1);
      i_usync_peer.nb = 0;
      a = rnd();
      wr(`USYNC_OFF_TX_BUF, a);
      wait_bits(9);
      chk(i_usync_peer.sh[17:9], {1'b1, a});
      repeat (30) @(posedge clk);
      wr(`USYNC_OFF_TX_STAT, 8'h90);
      wr(`USYNC_OFF_PENABLES, 8'h20);
      wr(`USYNC_OFF_INT_CTRL, 8'h80);
      a = rnd();
      send({1'b0, a}, 8);
      wr(`USYNC_OFF_RX_STAT, 8'ha0);
      poll(`USYNC_OFF_PFLAGS, 5, 1'b1, v);
      chk(v[5], 1'b1);
      repeat (3) @(posedge clk);
      chk(irq_req, 1'b1);
      rd(`USYNC_OFF_RX_STAT, v);
      chk(v, 8'h80);
      rd(`USYNC_OFF_RX_BUF, v);
      chk(v, a);
      wr(`USYNC_OFF_PENABLES, 8'h00);
      a = rnd();
      e = {a[0], rnd()};
      send(e, 9);
      send({1'b0, rnd()}, 9);
      wr(`USYNC_OFF_RX_STAT, 8'hd0);
      poll(`USYNC_OFF_RX_STAT, 1, 1'b1, v);
      chk(v, 8'hd2 | {7'h00, e[8]});
      rd(`USYNC_OFF_RX_BUF, v);
      chk(v, e[7:0]);
      wr(`USYNC_OFF_RX_STAT, 8'h80);
      rd(`USYNC_OFF_RX_STAT, v);
      chk(v[1], 1'b0);
      wr(`USYNC_OFF_TX_STAT, 8'h30);
      wr(`USYNC_OFF_PENABLES, 8'h10);
      a = rnd();
      b = rnd();
      wr(`USYNC_OFF_TX_BUF, a);
      repeat (4) @(posedge clk);
      wr(`USYNC_OFF_TX_BUF, b);
      sleep_mode <= 1'b1;
      rd(`USYNC_OFF_PFLAGS, v);
      chk(v[4], 1'b0);
      i_usync_peer.pulses(8);
      repeat (10) @(posedge clk);
      rd(`USYNC_OFF_PFLAGS, v);
      chk(v[4], 1'b1);
      chk(irq_req, 1'b1);
      i_usync_peer.pulses(8);
      @(posedge clk);
      chk(i_usync_peer.sh[17:2], {b, a});
      chk(hresp, 1'b0);
      end_sim();
   end
endmodule
